// ### core/cpmc_defines.svh
// offsets, field positions, reset values and timing counts of the clock/power/reset controller
`ifndef CPMC_DEFINES_SVH
`define CPMC_DEFINES_SVH
// ==========
// timing
`define CPMC_CLK_MHZ       200
`define CPMC_RST_HOLD_NS   100
`define CPMC_RST_HOLD_CYC  ((`CPMC_RST_HOLD_NS * `CPMC_CLK_MHZ + 999) / 1000)
`define CPMC_STEP_NS       1000
`define CPMC_STEP_CYC      ((`CPMC_STEP_NS * `CPMC_CLK_MHZ) / 1000)
// ==========
// register offsets
`define CPMC_ADR_CLKOUT    8'h00
`define CPMC_ADR_PWR       8'h04
`define CPMC_ADR_RST       8'h08
`define CPMC_ADR_CDIV      8'h0c
`define CPMC_ADR_STAT      8'h10
// ==========
// fields
`define CPMC_AUX_LSB       8
`define CPMC_PWR_DEEP_BIT  0
`define CPMC_PWR_HIB_BIT   1
`define CPMC_RST_SYS_BIT   0
`define CPMC_RST_CORE_BIT  1
`define CPMC_RST_FEN_BIT   4
`define CPMC_CAUSE_LSB     8
`define CPMC_CUR_LSB       8
// ==========
// clock output sources and dividers
`define CPMC_SEL_REF       3'h0
`define CPMC_SEL_CORE      3'h1
`define CPMC_SEL_SYS       3'h2
`define CPMC_SEL_CRYPTO    3'h3
`define CPMC_SEL_MEM       3'h4
`define CPMC_SEL_AUX       3'h5
`define CPMC_DIV_CORE      16
`define CPMC_DIV_SYS       8
`define CPMC_DIV_CRYPTO    8
`define CPMC_DIV_MEM       8
// ==========
// synchronised input bit positions
`define CPMC_IN_RSTN       6
`define CPMC_IN_LOCK       7
`define CPMC_IN_WAKE       8
// ==========
// reset values and cause bits
`define CPMC_AUX_RST       8'h01
`define CPMC_CDIV_RST      8'h01
// synchroniser idle levels: board reset input sits high
`define CPMC_SYNC_RST      9'h040
`define CPMC_C_HW          0
`define CPMC_C_FAULT       1
`define CPMC_C_SWSYS       2
`define CPMC_C_SWCORE      3
`endif

// ### core/cpmc_pkg.sv
// types of the clock/power/reset controller
package cpmc_pkg;
  typedef enum logic [1:0] {
    CPMC_FULL_ON = 2'b00,
    CPMC_DEEP    = 2'b01,
    CPMC_HIBER   = 2'b10,
    CPMC_RELOCK  = 2'b11
  } cpmc_mode_type;

  typedef struct packed {
    logic pll_en;
    logic pll_bypass;
    logic core_clk_en;
    logic sys_clk_en;
    logic core_power_on;
    logic async_block;
    logic pins_hiz;
  } cpmc_pwr_type;

  typedef struct packed {
    logic units_reset;
    logic core_reset;
  } cpmc_rst_type;

  typedef struct packed {
    logic [8:0]    sync1;
    logic [8:0]    sync2;
    logic [8:0]    prev;
    logic          ack;
    logic [31:0]   rdata;
    logic [2:0]    sel_req;
    logic [2:0]    sel_act;
    logic [7:0]    aux_half;
    logic [7:0]    cnt;
    logic          clk_out;
    cpmc_mode_type mode;
    logic          reg_wake;
    logic          fault_en;
    logic [3:0]    cause;
    logic          sys_rst;
    logic          core_rst;
    logic [15:0]   rst_cnt;
    logic [7:0]    div_tgt;
    logic [7:0]    div_cur;
    logic [15:0]   step_cnt;
  } cpmc_state_type;
endpackage

// ### core/cpmc_top.sv
// clock output selector, power mode sequencer and reset sequencing unit
`timescale 1ns/1ps
`include "cpmc_defines.svh"

// How it works
// - after reset the clock pin follows the reference clock until software picks another
// - sources are core clock by 16, system, crypto and memory by 8, aux programmable
// - the peripheral system clock has no select code at all
// - loss of pll lock may start a full hardware reset
// - full-on keeps the pll enabled and not bypassed, all clocks running
// - full-on is the mode after power-up and every system reset
// - deep sleep stops the pll, core and synchronous clocks, core stays powered
// - deep sleep blocks asynchronous units from internal and external memory
// - hibernate stops pll, clocks and the core supply
// - entering hibernate drops the regulator wake output so the regulator turns off
// - hibernate releases driven pins to high impedance, except the regulator wake output, which stays driven low
// - hardware or software events reset the whole chip or the core alone
// - during a system reset control registers take defaults and units are held
// - leaving a system reset frees the core ready to boot
// - the core clock divider may be changed while running
// - divider changes are applied one step at a time, not at once
module cpmc_top #(
  parameter int RST_HOLD = `CPMC_RST_HOLD_CYC,
  parameter int STEP_CYC = `CPMC_STEP_CYC
) (
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  // avalon-mm slave
  input  wire logic [7:0]        AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [31:0]       AVS_WRITEDATA,
  output logic [31:0]            AVS_READDATA,
  output logic                   AVS_WAITREQUEST,
  // clocks from the clock generator unit
  input  wire logic              REFERENCE_CLOCK_INPUT,
  input  wire logic              PROCESSOR_CORE_CLOCK,
  input  wire logic              MAIN_SYSTEM_CLOCK,
  input  wire logic              CRYPTO_DMA_SYSTEM_CLOCK,
  input  wire logic              MEMORY_INTERFACE_CLOCK,
  input  wire logic              AUXILIARY_OUTPUT_CLOCK,
  // board and pll status
  input  wire logic              HW_RESET_N,
  input  wire logic              PLL_LOCKED,
  input  wire logic              WAKE_EVENT,
  // pins
  output logic                   CLOCK_OUTPUT_PIN,
  output logic                   CLOCK_OUTPUT_PIN_OE,
  output logic                   REGULATOR_WAKE_OUTPUT,
  // controls to clock generator, units and core
  output cpmc_pkg::cpmc_pwr_type PWR_CTRL,
  output cpmc_pkg::cpmc_rst_type RST_CTRL,
  output logic [7:0]             CORE_DIV
);

  // ==========
  // state
  localparam cpmc_pkg::cpmc_state_type RST_S = '{
    sync1:    `CPMC_SYNC_RST,
    sync2:    `CPMC_SYNC_RST,
    prev:     `CPMC_SYNC_RST,
    sel_req:  `CPMC_SEL_REF,
    sel_act:  `CPMC_SEL_REF,
    aux_half: `CPMC_AUX_RST,
    mode:     cpmc_pkg::CPMC_FULL_ON,
    reg_wake: 1'b1,
    fault_en: 1'b1,
    sys_rst:  1'b1,
    core_rst: 1'b1,
    div_tgt:  `CPMC_CDIV_RST,
    div_cur:  `CPMC_CDIV_RST,
    default:  '0
  };

  cpmc_pkg::cpmc_state_type s_ff;
  cpmc_pkg::cpmc_state_type nxt_s;
  cpmc_pkg::cpmc_state_type dflt;
  logic [8:0]  rise;
  logic        wr_hit;
  logic        lock;
  logic        fault;
  logic        sw_sys;
  logic        sw_core;
  logic        hib_wake;
  logic        start;
  logic [3:0]  cause_set;
  logic [3:0]  cause_clr;
  logic [7:0]  half;

  function automatic logic [7:0] half_of(input logic [2:0] sel, input logic [7:0] aux);
    unique case (sel)
      `CPMC_SEL_CORE:   half_of = 8'(`CPMC_DIV_CORE / 2);
      `CPMC_SEL_SYS:    half_of = 8'(`CPMC_DIV_SYS / 2);
      `CPMC_SEL_CRYPTO: half_of = 8'(`CPMC_DIV_CRYPTO / 2);
      `CPMC_SEL_MEM:    half_of = 8'(`CPMC_DIV_MEM / 2);
      `CPMC_SEL_AUX:    half_of = aux;
      default:          half_of = 8'h01;
    endcase
  endfunction

  // ==========
  // next state
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.sync1 = {WAKE_EVENT, PLL_LOCKED, HW_RESET_N, AUXILIARY_OUTPUT_CLOCK, MEMORY_INTERFACE_CLOCK,
                   CRYPTO_DMA_SYSTEM_CLOCK, MAIN_SYSTEM_CLOCK, PROCESSOR_CORE_CLOCK, REFERENCE_CLOCK_INPUT};
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.prev = s_ff.sync2;
    rise = s_ff.sync2 & ~s_ff.prev;
    lock = s_ff.sync2[`CPMC_IN_LOCK];
    wr_hit = AVS_WRITE & s_ff.ack & ~s_ff.sys_rst;
    sw_sys = 1'b0;
    sw_core = 1'b0;
    hib_wake = 1'b0;
    cause_clr = 4'h0;
    // pll unlock while running full speed
    fault = s_ff.fault_en & s_ff.prev[`CPMC_IN_LOCK] & ~lock & (s_ff.mode == cpmc_pkg::CPMC_FULL_ON)
            & ~s_ff.sys_rst;

    // avalon: one wait cycle, read data prepared while waitrequest is high
    nxt_s.ack = (AVS_READ | AVS_WRITE) & ~s_ff.ack;
    if (AVS_READ & ~s_ff.ack)
    begin
      unique case (AVS_ADDRESS)
        `CPMC_ADR_CLKOUT: nxt_s.rdata = {16'h0000, s_ff.aux_half, 5'h00, s_ff.sel_req};
        `CPMC_ADR_PWR:    nxt_s.rdata = {30'h0, s_ff.mode};
        `CPMC_ADR_RST:    nxt_s.rdata = {20'h0, s_ff.cause, 3'h0, s_ff.fault_en, 2'h0, s_ff.core_rst,
                                         s_ff.sys_rst};
        `CPMC_ADR_CDIV:   nxt_s.rdata = {16'h0000, s_ff.div_cur, s_ff.div_tgt};
        `CPMC_ADR_STAT:   nxt_s.rdata = {24'h0, (s_ff.sel_act != s_ff.sel_req), s_ff.sel_act, lock,
                                         s_ff.reg_wake, s_ff.clk_out, 1'b0};
        default:          nxt_s.rdata = 32'h0000_0000;
      endcase
    end

    // register writes
    if (wr_hit && AVS_ADDRESS == `CPMC_ADR_CLKOUT)
    begin
      if (AVS_WRITEDATA[2:0] <= `CPMC_SEL_AUX)
        nxt_s.sel_req = AVS_WRITEDATA[2:0];
      nxt_s.aux_half = (AVS_WRITEDATA[`CPMC_AUX_LSB +: 8] == 8'h00) ? 8'h01 : AVS_WRITEDATA[`CPMC_AUX_LSB +: 8];
    end
    if (wr_hit && AVS_ADDRESS == `CPMC_ADR_RST)
    begin
      nxt_s.fault_en = AVS_WRITEDATA[`CPMC_RST_FEN_BIT];
      cause_clr = AVS_WRITEDATA[`CPMC_CAUSE_LSB +: 4];
      sw_sys = AVS_WRITEDATA[`CPMC_RST_SYS_BIT];
      sw_core = AVS_WRITEDATA[`CPMC_RST_CORE_BIT] & ~AVS_WRITEDATA[`CPMC_RST_SYS_BIT];
    end
    if (wr_hit && AVS_ADDRESS == `CPMC_ADR_CDIV)
      nxt_s.div_tgt = (AVS_WRITEDATA[7:0] == 8'h00) ? 8'h01 : AVS_WRITEDATA[7:0];

    // power mode sequencer
    unique case (s_ff.mode)
      cpmc_pkg::CPMC_FULL_ON:
      begin
        if (wr_hit && AVS_ADDRESS == `CPMC_ADR_PWR && AVS_WRITEDATA[`CPMC_PWR_HIB_BIT])
        begin
          nxt_s.mode = cpmc_pkg::CPMC_HIBER;
          nxt_s.reg_wake = 1'b0;
        end
        else if (wr_hit && AVS_ADDRESS == `CPMC_ADR_PWR && AVS_WRITEDATA[`CPMC_PWR_DEEP_BIT])
          nxt_s.mode = cpmc_pkg::CPMC_DEEP;
      end
      cpmc_pkg::CPMC_DEEP:
      begin
        if (rise[`CPMC_IN_WAKE])
          nxt_s.mode = cpmc_pkg::CPMC_RELOCK;
      end
      cpmc_pkg::CPMC_RELOCK:
      begin
        if (lock)
          nxt_s.mode = cpmc_pkg::CPMC_FULL_ON;
      end
      cpmc_pkg::CPMC_HIBER:
      begin
        // core supply is gone: waking means powering up through a full reset
        if (rise[`CPMC_IN_WAKE])
          hib_wake = 1'b1;
      end
    endcase

    // smooth core divider stepping
    if (s_ff.mode == cpmc_pkg::CPMC_FULL_ON)
    begin
      if (s_ff.step_cnt == 16'h0000)
      begin
        nxt_s.step_cnt = 16'(STEP_CYC - 1);
        if (s_ff.div_cur < s_ff.div_tgt)
          nxt_s.div_cur = s_ff.div_cur + 8'h01;
        else if (s_ff.div_cur > s_ff.div_tgt)
          nxt_s.div_cur = s_ff.div_cur - 8'h01;
      end
      else
        nxt_s.step_cnt = s_ff.step_cnt - 16'h0001;
    end

    // clock output: switch only while low, then divide selected source
    half = half_of(s_ff.sel_act, s_ff.aux_half);
    if (s_ff.sel_act != s_ff.sel_req && !s_ff.clk_out)
    begin
      nxt_s.sel_act = s_ff.sel_req;
      nxt_s.cnt = 8'h00;
      nxt_s.clk_out = 1'b0;
    end
    else if (s_ff.sel_act == `CPMC_SEL_REF)
      nxt_s.clk_out = s_ff.sync2[0];
    else if (rise[s_ff.sel_act])
    begin
      if (s_ff.cnt == half - 8'h01)
      begin
        nxt_s.cnt = 8'h00;
        nxt_s.clk_out = ~s_ff.clk_out;
      end
      else
        nxt_s.cnt = s_ff.cnt + 8'h01;
    end

    // reset sequencing
    start = ~s_ff.sync2[`CPMC_IN_RSTN] | fault | sw_sys | hib_wake;
    cause_set = {sw_core, sw_sys, fault, hib_wake | ~s_ff.sync2[`CPMC_IN_RSTN]};
    nxt_s.cause = (s_ff.cause & ~cause_clr) | cause_set;
    if (start)
    begin
      dflt = RST_S;
      dflt.sync1 = nxt_s.sync1;
      dflt.sync2 = nxt_s.sync2;
      dflt.prev = nxt_s.prev;
      dflt.ack = nxt_s.ack;
      dflt.rdata = nxt_s.rdata;
      dflt.cause = nxt_s.cause;
      nxt_s = dflt;
    end
    else
    begin
      dflt = RST_S;
      if (sw_core)
      begin
        nxt_s.core_rst = 1'b1;
        nxt_s.rst_cnt = 16'h0000;
      end
      else if (s_ff.sys_rst | s_ff.core_rst)
      begin
        if (s_ff.rst_cnt == 16'(RST_HOLD - 1))
        begin
          nxt_s.sys_rst = 1'b0;
          nxt_s.core_rst = 1'b0;
        end
        else
          nxt_s.rst_cnt = s_ff.rst_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      s_ff <= RST_S;
    else
      s_ff <= nxt_s;
  end

  // ==========
  // outputs
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~s_ff.ack;
  assign AVS_READDATA = s_ff.rdata;
  assign CLOCK_OUTPUT_PIN = s_ff.clk_out;
  assign CLOCK_OUTPUT_PIN_OE = (s_ff.mode != cpmc_pkg::CPMC_HIBER);
  assign REGULATOR_WAKE_OUTPUT = s_ff.reg_wake;
  assign CORE_DIV = s_ff.div_cur;
  assign PWR_CTRL.pll_en = (s_ff.mode == cpmc_pkg::CPMC_FULL_ON) | (s_ff.mode == cpmc_pkg::CPMC_RELOCK);
  assign PWR_CTRL.pll_bypass = 1'b0;
  assign PWR_CTRL.core_clk_en = (s_ff.mode == cpmc_pkg::CPMC_FULL_ON);
  assign PWR_CTRL.sys_clk_en = (s_ff.mode == cpmc_pkg::CPMC_FULL_ON);
  assign PWR_CTRL.core_power_on = (s_ff.mode != cpmc_pkg::CPMC_HIBER);
  assign PWR_CTRL.async_block = (s_ff.mode == cpmc_pkg::CPMC_DEEP) | (s_ff.mode == cpmc_pkg::CPMC_RELOCK);
  assign PWR_CTRL.pins_hiz = (s_ff.mode == cpmc_pkg::CPMC_HIBER);
  assign RST_CTRL.units_reset = s_ff.sys_rst;
  assign RST_CTRL.core_reset = s_ff.core_rst;

  // ==========
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  property p_ref_default;
    $past(RESET) |-> s_ff.sel_act == `CPMC_SEL_REF && s_ff.sel_req == `CPMC_SEL_REF;
  endproperty
  a_ref_default: assert property (p_ref_default) else $error("clock out not on reference");

  property p_no_periph;
    s_ff.sel_act <= `CPMC_SEL_AUX && s_ff.sel_req <= `CPMC_SEL_AUX;
  endproperty
  a_no_periph: assert property (p_no_periph) else $error("illegal clock out source");

  property p_fault;
    fault |=> s_ff.sys_rst && s_ff.core_rst && s_ff.cause[`CPMC_C_FAULT];
  endproperty
  a_fault: assert property (p_fault) else $error("pll fault gave no reset");

  property p_full_on;
    s_ff.mode == cpmc_pkg::CPMC_FULL_ON |-> PWR_CTRL.pll_en && !PWR_CTRL.pll_bypass && PWR_CTRL.sys_clk_en;
  endproperty
  a_full_on: assert property (p_full_on) else $error("full-on clocks wrong");

  property p_deep;
    s_ff.mode == cpmc_pkg::CPMC_DEEP |-> !PWR_CTRL.pll_en && !PWR_CTRL.core_clk_en && PWR_CTRL.core_power_on
      && PWR_CTRL.async_block;
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep controls wrong");

  property p_hiber;
    s_ff.mode == cpmc_pkg::CPMC_HIBER |-> !PWR_CTRL.core_power_on && !REGULATOR_WAKE_OUTPUT
      && PWR_CTRL.pins_hiz && !CLOCK_OUTPUT_PIN_OE;
  endproperty
  a_hiber: assert property (p_hiber) else $error("hibernate controls wrong");

  property p_rst_dflt;
    s_ff.sys_rst |-> s_ff.mode == cpmc_pkg::CPMC_FULL_ON && s_ff.div_tgt == `CPMC_CDIV_RST && s_ff.reg_wake;
  endproperty
  a_rst_dflt: assert property (p_rst_dflt) else $error("register not default in reset");

  property p_release;
    $fell(s_ff.sys_rst) |-> !s_ff.core_rst && $past(s_ff.rst_cnt) == 16'(RST_HOLD - 1);
  endproperty
  a_release: assert property (p_release) else $error("bad system reset release");

  property p_step;
    $changed(s_ff.div_cur) && !s_ff.sys_rst |-> $past(s_ff.step_cnt) == 16'h0000;
  endproperty
  a_step: assert property (p_step) else $error("divider jumped");

  property p_switch;
    $changed(s_ff.sel_act) && !s_ff.sys_rst |-> !$past(s_ff.clk_out) && !s_ff.clk_out;
  endproperty
  a_switch: assert property (p_switch) else $error("source switched while high");

  property p_wake;
    s_ff.mode == cpmc_pkg::CPMC_DEEP && rise[`CPMC_IN_WAKE] && !start |=> s_ff.mode == cpmc_pkg::CPMC_RELOCK
      ##[1:1000] s_ff.mode == cpmc_pkg::CPMC_FULL_ON;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not restore full-on");

endmodule

// ### sim/cpmc_board_model.sv
// board side model: core voltage regulator and clock pin load
`timescale 1ns/1ps
module cpmc_board_model #(
  parameter int RAMP = 8
) (
  // clock and reset
  input  wire logic CLK,
  input  wire logic RESET,
  // regulator enable and clock pin from the device
  input  wire logic REG_EN,
  input  wire logic PIN,
  input  wire logic PIN_OE,
  // supply state and pin level seen on the board
  output logic      SUPPLY_ON,
  output logic      PIN_LEVEL
);
  logic [7:0] ramp_ff;

  // ==========
  // regulator: supply drops at once when released, ramps back when enabled
  always_ff @(posedge CLK)
    if (RESET || !REG_EN)
      ramp_ff <= 8'h00;
    else if (ramp_ff != 8'(RAMP))
      ramp_ff <= ramp_ff + 8'h01;

  assign SUPPLY_ON = REG_EN && (ramp_ff == 8'(RAMP));

  // ==========
  // pull-down on the board when the pin is released
  assign PIN_LEVEL = PIN_OE ? PIN : 1'b0;
endmodule

// ### sim/tb_top.sv
// self-checking testbench of the clock/power/reset controller
`timescale 1ns/1ps
module tb_top;
  // ==========
  // signals
  logic                   clk = 1'b0;
  logic                   reset = 1'b1;
  logic [7:0]             avs_address = 8'h00;
  logic                   avs_read = 1'b0;
  logic                   avs_write = 1'b0;
  logic [31:0]            avs_writedata = 32'h0;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic                   ref_ck = 1'b0, core_ck = 1'b0, sys_ck = 1'b0, cry_ck = 1'b0, mem_ck = 1'b0, aux_ck = 1'b0;
  logic                   hw_reset_n = 1'b1, pll_locked = 1'b0, wake_event = 1'b0, lock_kill = 1'b0;
  logic                   pin, pin_oe, reg_wake, supply_on, pin_level;
  cpmc_pkg::cpmc_pwr_type pwr;
  cpmc_pkg::cpmc_rst_type rst;
  logic [7:0]             core_div;
  logic [3:0]             lock_cnt = 4'h0;
  realtime                rise_t = 0;
  int                     short_pulses = 0, n_errors = 0, cmp_count = 0;
  localparam int          STEP = 4;
  localparam logic [31:0] FULL = 32'h5c, DEEP = 32'h06, HIB = 32'h01;

  always #2.5 clk = ~clk;
  always #20 ref_ck = ~ref_ck;
  always #10 core_ck = ~core_ck;
  always #15 sys_ck = ~sys_ck;
  always #25 cry_ck = ~cry_ck;
  always #30 mem_ck = ~mem_ck;
  always #10 aux_ck = ~aux_ck;

  // pll lock follows enable after a settling time
  always @(posedge clk)
  begin
    if (!pwr.pll_en || lock_kill) lock_cnt <= 4'h0;
    else if (lock_cnt != 4'ha) lock_cnt <= lock_cnt + 4'h1;
    pll_locked <= (lock_cnt == 4'ha) && pwr.pll_en && !lock_kill;
  end

  // truncated high pulses on the clock pin
  always @(posedge pin) rise_t = $realtime;
  always @(negedge pin) if (rise_t > 0 && $realtime - rise_t < 19.0) short_pulses++;

  cpmc_top #(.RST_HOLD(8), .STEP_CYC(STEP)) cpmc_top_i (
    .CLK(clk), .RESET(reset), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .REFERENCE_CLOCK_INPUT(ref_ck), .PROCESSOR_CORE_CLOCK(core_ck), .MAIN_SYSTEM_CLOCK(sys_ck),
    .CRYPTO_DMA_SYSTEM_CLOCK(cry_ck), .MEMORY_INTERFACE_CLOCK(mem_ck), .AUXILIARY_OUTPUT_CLOCK(aux_ck),
    .HW_RESET_N(hw_reset_n), .PLL_LOCKED(pll_locked), .WAKE_EVENT(wake_event), .CLOCK_OUTPUT_PIN(pin),
    .CLOCK_OUTPUT_PIN_OE(pin_oe), .REGULATOR_WAKE_OUTPUT(reg_wake), .PWR_CTRL(pwr), .RST_CTRL(rst),
    .CORE_DIV(core_div));

  cpmc_board_model cpmc_board_model_i (.CLK(clk), .RESET(reset), .REG_EN(reg_wake), .PIN(pin),
    .PIN_OE(pin_oe), .SUPPLY_ON(supply_on), .PIN_LEVEL(pin_level));

  // ==========
  // shared tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 64);
    rd = avs_readdata;
    chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(name, exp, x);
  endtask

  task automatic wait_rst(input string name, input logic [1:0] exp, input int lim);
    int n;
    n = 0;
    while (rst !== exp && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    chk(name, {30'h0, exp}, {30'h0, rst});
  endtask

  task automatic period(input string name, input int exp);
    realtime t0, t1, t2;
    repeat (2) @(posedge pin);
    t0 = $realtime;
    @(negedge pin);
    t1 = $realtime;
    @(posedge pin);
    t2 = $realtime;
    chk({name, "_period"}, exp, 32'($rtoi(t2 - t0 + 0.5)));
    chk({name, "_high"}, exp / 2, 32'($rtoi(t1 - t0 + 0.5)));
  endtask

  // ==========
  // scenarios
  task automatic t_defaults;
    rdchk("clkout_reg", 8'h00, 32'h100);
    period("ref", 40);
    chk("pwr_full", FULL, 32'(pwr));
    rdchk("pwr_mode", 8'h04, 32'h0);
    rdchk("rst_reg", 8'h08, 32'h10);
    rdchk("cdiv_reg", 8'h0c, 32'h101);
    rdchk("unmapped", 8'h20, 32'h0);
    chk("pin_oe", 32'h1, {31'h0, pin_oe});
  endtask

  task automatic t_sources;
    int per[5] = '{320, 240, 400, 480, 120};
    for (int s = 1; s <= 5; s++)
    begin
      wr(8'h00, 32'h300 | 32'(s));
      period("sel", per[s - 1]);
    end
    wr(8'h00, 32'h306);
    rdchk("sel_reserved", 8'h00, 32'h305);
    period("sel_kept", 120);
    chk("short_pulses", 32'h0, 32'(short_pulses));
  endtask

  task automatic t_resets;
    lock_kill <= 1'b1;
    wait_rst("fault_reset", 2'b11, 20);
    lock_kill <= 1'b0;
    wait_rst("fault_release", 2'b00, 200);
    rdchk("fault_cause", 8'h08, 32'h210);
    rdchk("clkout_restored", 8'h00, 32'h100);
    wr(8'h08, 32'hf10);
    hw_reset_n <= 1'b0;
    wait_rst("hw_reset", 2'b11, 20);
    hw_reset_n <= 1'b1;
    wait_rst("hw_release", 2'b00, 200);
    rdchk("hw_cause", 8'h08, 32'h110);
    wr(8'h08, 32'hf10);
    wr(8'h08, 32'h11);
    wait_rst("sw_sys_reset", 2'b11, 20);
    wr(8'h00, 32'h302);
    wait_rst("sw_sys_release", 2'b00, 200);
    rdchk("write_in_reset", 8'h00, 32'h100);
    rdchk("sw_sys_cause", 8'h08, 32'h410);
    wr(8'h08, 32'hf10);
    wr(8'h08, 32'h12);
    wait_rst("sw_core_reset", 2'b01, 20);
    wait_rst("sw_core_release", 2'b00, 200);
    rdchk("sw_core_cause", 8'h08, 32'h810);
    wr(8'h08, 32'hf10);
    wr(8'h08, 32'h0);
    lock_kill <= 1'b1;
    repeat (20) @(posedge clk);
    chk("fault_masked", 32'h0, {30'h0, rst});
    lock_kill <= 1'b0;
    repeat (20) @(posedge clk);
    rdchk("fault_masked_cause", 8'h08, 32'h0);
    wr(8'h08, 32'h10);
  endtask

  task automatic t_core_div;
    int last, gap, mingap, changes;
    last = 1;
    gap = 0;
    mingap = 1000;
    changes = 0;
    wr(8'h0c, 32'h4);
    for (int n = 0; n < 100; n++)
    begin
      @(posedge clk);
      gap++;
      if (core_div !== 8'(last))
      begin
        chk("div_step", 32'(last + 1), {24'h0, core_div});
        if (changes > 0 && gap < mingap) mingap = gap;
        last = last + 1;
        gap = 0;
        changes++;
      end
    end
    chk("div_final", 32'h4, {24'h0, core_div});
    chk("div_changes", 32'h3, 32'(changes));
    chk("div_spacing", 32'h1, {31'h0, mingap >= STEP});
    rdchk("cdiv_applied", 8'h0c, 32'h404);
  endtask

  task automatic t_power;
    int n;
    wr(8'h04, 32'h1);
    repeat (3) @(posedge clk);
    chk("deep_ctrl", DEEP, 32'(pwr));
    chk("deep_supply", 32'h1, {31'h0, supply_on});
    rdchk("deep_mode", 8'h04, 32'h1);
    wake_event <= 1'b1;
    n = 0;
    while (32'(pwr) !== FULL && n < 80)
    begin
      @(posedge clk);
      n++;
    end
    chk("wake_full", FULL, 32'(pwr));
    wake_event <= 1'b0;
    rdchk("wake_mode", 8'h04, 32'h0);
    rdchk("hib_save", 8'h0c, 32'h404);
    wr(8'h04, 32'h2);
    repeat (12) @(posedge clk);
    chk("hib_ctrl", HIB, 32'(pwr));
    chk("hib_reg_wake", 32'h0, {31'h0, reg_wake});
    chk("hib_supply", 32'h0, {31'h0, supply_on});
    chk("hib_pin_oe", 32'h0, {31'h0, pin_oe});
    chk("hib_pin_level", 32'h0, {31'h0, pin_level});
    wake_event <= 1'b1;
    wait_rst("hib_wake_reset", 2'b11, 20);
    wake_event <= 1'b0;
    wait_rst("hib_wake_release", 2'b00, 200);
    repeat (10) @(posedge clk);
    chk("wake_supply", 32'h1, {31'h0, supply_on});
    rdchk("hib_cause", 8'h08, 32'h110);
    rdchk("hib_exit_mode", 8'h04, 32'h0);
    rdchk("hib_lost", 8'h0c, 32'h101);
  endtask

  // ==========
  // verdict
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    wait_rst("por_release", 2'b00, 100);
    t_defaults;
    t_sources;
    t_resets;
    t_core_div;
    t_power;
    summarize;
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    n_errors++;
    summarize;
  end
endmodule
